//--- stc_pin_src.sv
// clock source model driving the count clock or oscillator pin
`timescale 1ns/1ns
`default_nettype none
module stc_pin_src (
    input wire logic clk,
    input wire logic emit,
    input wire logic use_osc,
    output logic ext_count_clock_pin,
    output logic osc_input_pin
);
    logic [2:0] phase_r;
    // ------------------------------------------------------------
    // one rising edge every 8 clocks while emit, idle low otherwise
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!emit) begin
            phase_r <= 3'h0;
        end else begin
            phase_r <= phase_r + 3'h1;
        end
    end
    assign ext_count_clock_pin = emit & phase_r[2] & !use_osc;
    assign osc_input_pin = emit & phase_r[2] & use_osc;
endmodule
`default_nettype wire

//--- stc_pkg.sv
// constants for the sixteen bit timer counter
package stc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_COUNT_LO = 8'h0e;
    localparam logic [7:0] OFS_COUNT_HI = 8'h0f;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLES = 8'h8c;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_RUN = 0;
    localparam int unsigned BIT_CLK_SRC = 1;
    localparam int unsigned BIT_SYNC_DIS = 2;
    localparam int unsigned BIT_OSC_EN = 3;
    localparam int unsigned BIT_PS_LO = 4;
    localparam int unsigned BIT_PS_HI = 5;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [7:0] CONTROL_RD_MASK = 8'h3f;
    localparam int unsigned BIT_OVF = 0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // ------------------------------------------------------------
    // prescale codes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV2 = 2'h1;
    localparam logic [1:0] PS_DIV4 = 2'h2;
    localparam logic [1:0] PS_DIV8 = 2'h3;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned INSTR_NS = 40;
    localparam int unsigned INSTR_CYCLES = (INSTR_NS * CLK_MHZ) / 1000;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_CYCLES - 1);
endpackage

//--- stc_timer.sv
// sixteen bit timer counter with prescaler, oscillator pin control and overflow flag
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module stc_timer
    import stc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [stc_pkg::ADDR_W-1:0] addr,
    input wire logic [stc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [stc_pkg::DATA_W-1:0] rdata,
    input wire logic ext_count_clock_pin,
    input wire logic osc_input_pin,
    input wire logic [1:0] port_c_direction,
    input wire logic sleep,
    input wire logic special_event_trigger,
    output logic low_freq_osc_enable,
    output logic [1:0] port_c_oe,
    output logic overflow_irq
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] ps_limit(input logic [1:0] code);
        case (code)
            PS_DIV2: ps_limit = 3'h1;
            PS_DIV4: ps_limit = 3'h3;
            PS_DIV8: ps_limit = 3'h7;
            default: ps_limit = 3'h0;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0] control_r;
    logic [15:0] count_r;
    logic overflow_flag_r;
    logic overflow_irq_enable_r;
    logic [7:0] rdata_r;
    logic [1:0] oe_r;
    logic osc_en_r;
    logic irq_r;
    logic [1:0] instr_div_r;
    logic [2:0] ps_cnt_r;
    logic [1:0] pin_sync_r;
    logic [1:0] osc_sync_r;
    logic ext_prev_r;
    logic ext_retime_r;
    logic ext_retime_prev_r;

    logic count_run_enable;
    logic clock_source_select;
    logic ext_sync_disable;
    logic [1:0] prescale_sel;
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic wr_flags;
    logic wr_en;
    logic count_wr;
    logic ext_level;
    logic ext_edge;
    logic instr_tick;
    logic src_tick;
    logic ps_tick;
    logic inc;
    logic wrap;
    logic trig_clear;

    assign count_run_enable = control_r[BIT_RUN];
    assign clock_source_select = control_r[BIT_CLK_SRC];
    assign ext_sync_disable = control_r[BIT_SYNC_DIS];
    assign prescale_sel = control_r[BIT_PS_HI:BIT_PS_LO];
    assign wr_ctrl = wr && hit(addr, OFS_CONTROL);
    assign wr_lo = wr && hit(addr, OFS_COUNT_LO);
    assign wr_hi = wr && hit(addr, OFS_COUNT_HI);
    assign wr_flags = wr && hit(addr, OFS_IRQ_FLAGS);
    assign wr_en = wr && hit(addr, OFS_IRQ_ENABLES);
    assign count_wr = wr_lo || wr_hi;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_r <= CONTROL_RESET;
        end else if (wr_ctrl) begin
            control_r <= wdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // oscillator enable and pin direction
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_en_r <= 1'b0;
            oe_r <= 2'h0;
        end else begin
            // sleep deliberately has no say here
            osc_en_r <= control_r[BIT_OSC_EN];
            oe_r <= control_r[BIT_OSC_EN] ? 2'h0 : ~port_c_direction;
        end
    end

    // ------------------------------------------------------------
    // external input synchronizers and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_sync_r <= 2'h0;
            osc_sync_r <= 2'h0;
            ext_prev_r <= 1'b0;
            ext_retime_r <= 1'b0;
            ext_retime_prev_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], ext_count_clock_pin};
            osc_sync_r <= {osc_sync_r[0], osc_input_pin};
            ext_prev_r <= ext_level;
            ext_retime_r <= ext_level;
            ext_retime_prev_r <= ext_retime_r;
        end
    end

    assign ext_level = osc_en_r ? osc_sync_r[1] : pin_sync_r[1];

    always_comb begin
        if (ext_sync_disable) begin
            ext_edge = ext_level && !ext_prev_r;
        end else begin
            ext_edge = ext_retime_r && !ext_retime_prev_r;
        end
    end

    // ------------------------------------------------------------
    // instruction cycle and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            instr_div_r <= 2'h0;
        end else if (instr_div_r == INSTR_LAST) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
        end
    end

    assign instr_tick = (instr_div_r == INSTR_LAST);
    assign src_tick = clock_source_select ? ext_edge : instr_tick;
    assign ps_tick = src_tick && (ps_cnt_r == ps_limit(prescale_sel));
    assign inc = count_run_enable && ps_tick;
    assign wrap = inc && (count_r == COUNT_MAX);
    assign trig_clear = special_event_trigger && !count_wr;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ps_cnt_r <= 3'h0;
        end else if (count_wr || trig_clear || wr_ctrl) begin
            ps_cnt_r <= 3'h0;
        end else if (count_run_enable && src_tick) begin
            ps_cnt_r <= ps_tick ? 3'h0 : ps_cnt_r + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // sixteen bit count
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= COUNT_RESET;
        end else if (count_wr) begin
            if (wr_lo) begin
                count_r[7:0] <= wdata;
            end
            if (wr_hi) begin
                count_r[15:8] <= wdata;
            end
        end else if (special_event_trigger) begin
            count_r <= COUNT_RESET;
        end else if (inc) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // overflow flag and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_flag_r <= 1'b0;
        end else if (wrap && !count_wr && !special_event_trigger) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_flags) begin
            overflow_flag_r <= wdata[BIT_OVF];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_irq_enable_r <= 1'b0;
        end else if (wr_en) begin
            overflow_irq_enable_r <= wdata[BIT_OVF];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= overflow_flag_r && overflow_irq_enable_r;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            case (addr)
                OFS_CONTROL: rdata_r <= {2'h0, control_r} & CONTROL_RD_MASK;
                OFS_COUNT_LO: rdata_r <= count_r[7:0];
                OFS_COUNT_HI: rdata_r <= count_r[15:8];
                OFS_IRQ_FLAGS: rdata_r <= {7'h00, overflow_flag_r};
                OFS_IRQ_ENABLES: rdata_r <= {7'h00, overflow_irq_enable_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign low_freq_osc_enable = osc_en_r;
    assign port_c_oe = oe_r;
    assign overflow_irq = irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_hold_when_off: assert property (
        (!count_run_enable && !count_wr && !special_event_trigger) |=> $stable(count_r))
        else $error("count moved while stopped");
    a_inc_by_one: assert property (
        (inc && !count_wr && !special_event_trigger && count_r != COUNT_MAX)
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("count did not advance by one");
    a_wrap_sets_flag: assert property (
        (wrap && !count_wr && !special_event_trigger) |=> (overflow_flag_r && count_r == 16'h0000))
        else $error("wrap did not set overflow flag");
    a_trig_clears: assert property (
        (special_event_trigger && !count_wr) |=> count_r == 16'h0000)
        else $error("trigger did not clear count");
    a_trig_no_flag: assert property (
        (special_event_trigger && !overflow_flag_r && !wr_flags) |=> !overflow_flag_r)
        else $error("trigger set overflow flag");
    a_write_beats_trig: assert property (
        (special_event_trigger && wr_lo && !wr_hi) |=> count_r[7:0] == $past(wdata))
        else $error("trigger overrode count write");
    a_irq_gated: assert property (
        (!overflow_irq_enable_r ##1 !overflow_irq_enable_r) |-> !overflow_irq)
        else $error("interrupt without enable");
    a_osc_pins_in: assert property (
        (control_r[BIT_OSC_EN] ##1 control_r[BIT_OSC_EN]) |-> port_c_oe == 2'h0)
        else $error("oscillator pins driven");
    a_unimpl_zero: assert property (
        (rd && addr == OFS_CONTROL) |=> rdata[7:6] == 2'h0)
        else $error("unimplemented control bits nonzero");
    a_timer_no_ext: assert property (
        (!clock_source_select && !instr_tick) |-> !src_tick)
        else $error("external edge counted in timer mode");

    c_wrap: cover property (wrap);
    c_trig: cover property (special_event_trigger && count_run_enable);
    c_ext_div8: cover property (inc && clock_source_select && prescale_sel == PS_DIV8);
    c_irq: cover property (overflow_irq && sleep);
endmodule
`default_nettype wire

//--- test_stc_timer.sv
// self-checking bench for the sixteen bit timer counter
`timescale 1ns/1ns
`default_nettype none
module test_stc_timer;
    import stc_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic trig = 1'b0;
    logic emit = 1'b0;
    logic use_osc = 1'b0;
    logic [1:0] dir = 2'h0;
    logic [7:0] rdata;
    logic ext_pin, osc_pin, osc_en, irq;
    logic [1:0] oe;
    logic [7:0] v;
    int mismatches = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    stc_timer dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ext_count_clock_pin(ext_pin), .osc_input_pin(osc_pin),
        .port_c_direction(dir), .sleep(sleep), .special_event_trigger(trig),
        .low_freq_osc_enable(osc_en), .port_c_oe(oe), .overflow_irq(irq));
    stc_pin_src src (.clk(clk), .emit(emit), .use_osc(use_osc), .ext_count_clock_pin(ext_pin),
        .osc_input_pin(osc_pin));
    // ------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic t = 1'b0);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        trig <= t;
        @(posedge clk);
        wr <= 1'b0;
        trig <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic zero_count();
        wr_reg(OFS_COUNT_LO, 8'h00);
        wr_reg(OFS_COUNT_HI, 8'h00);
    endtask
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(OFS_CONTROL, v);
        check({8'h00, v}, 16'h0000);
        rd_reg(OFS_IRQ_FLAGS, v);
        check({15'h0, v[0]}, 16'h0000);
        check({15'h0, osc_en}, 16'h0000);
        $display("test reset done");
        wr_reg(OFS_CONTROL, 8'hff);
        rd_reg(OFS_CONTROL, v);
        check({8'h00, v}, 16'h003f);
        check({13'h0, oe, osc_en}, 16'h0001);
        wr_reg(OFS_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        check({13'h0, oe, osc_en}, 16'h0006);
        dir <= 2'h1;
        repeat (2) @(posedge clk);
        check({13'h0, oe, osc_en}, 16'h0004);
        $display("test control done");
        wr_reg(OFS_COUNT_LO, 8'h12);
        repeat (40) @(posedge clk);
        rd_reg(OFS_COUNT_LO, v);
        check({8'h00, v}, 16'h0012);
        $display("test hold done");
        for (int p = 0; p < 4; p++) begin
            zero_count();
            wr_reg(OFS_CONTROL, {2'h0, 2'(p), 1'b0, 1'(p), 1'b0, 1'b1});
            repeat (40 << p) @(posedge clk);
            wr_reg(OFS_CONTROL, 8'h00);
            rd_reg(OFS_COUNT_LO, v);
            check({15'h0, v >= 8'h09 && v <= 8'h0b}, 16'h0001);
        end
        $display("test timer prescale done");
        sleep <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            use_osc <= 1'(m >> 1);
            zero_count();
            wr_reg(OFS_CONTROL, {2'h0, 2'(m), 1'(m >> 1), 1'(m), 1'b1, 1'b1});
            repeat (20) @(posedge clk);
            emit <= 1'b1;
            repeat (64) @(posedge clk);
            emit <= 1'b0;
            repeat (20) @(posedge clk);
            rd_reg(OFS_COUNT_LO, v);
            check({8'h00, v}, 16'(8 >> m));
        end
        use_osc <= 1'b0;
        wr_reg(OFS_CONTROL, 8'h00);
        $display("test external done");
        wr_reg(OFS_COUNT_LO, 8'hfe);
        wr_reg(OFS_COUNT_HI, 8'hff);
        wr_reg(OFS_IRQ_ENABLES, 8'h00);
        wr_reg(OFS_CONTROL, 8'h01);
        repeat (20) @(posedge clk);
        wr_reg(OFS_CONTROL, 8'h00);
        rd_reg(OFS_COUNT_HI, v);
        check({8'h00, v}, 16'h0000);
        rd_reg(OFS_IRQ_FLAGS, v);
        check({15'h0, v[0]}, 16'h0001);
        check({15'h0, irq}, 16'h0000);
        wr_reg(OFS_IRQ_ENABLES, 8'h01);
        repeat (3) @(posedge clk);
        check({15'h0, irq}, 16'h0001);
        wr_reg(OFS_IRQ_FLAGS, 8'h00);
        repeat (3) @(posedge clk);
        check({15'h0, irq}, 16'h0000);
        sleep <= 1'b0;
        $display("test overflow done");
        wr_reg(OFS_COUNT_LO, 8'h55);
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        rd_reg(OFS_COUNT_LO, v);
        check({8'h00, v}, 16'h0000);
        rd_reg(OFS_IRQ_FLAGS, v);
        check({15'h0, v[0]}, 16'h0000);
        wr_reg(OFS_COUNT_LO, 8'h33, 1'b1);
        rd_reg(OFS_COUNT_LO, v);
        check({8'h00, v}, 16'h0033);
        rd_reg(8'h55, v);
        check({8'h00, v}, 16'h0000);
        $display("test trigger done");
        end_sim();
    end
endmodule
`default_nettype wire
